/* hdl/fspl_pkg.sv */
// constants, command codes and types of the sector protection lock
package fspl_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ      = 200;
    localparam int PWD_CHECK_NS = 1000;
    // least time, rounded up to whole cycles
    localparam int CHECK_CYCLES = (PWD_CHECK_NS * CLK_MHZ + 999) / 1000;
    localparam int POLL_CYCLES  = 4;

    // ------------------------------------------------------------
    // widths and field positions
    // ------------------------------------------------------------
    localparam int ADDR_W    = 24;
    localparam int DATA_W    = 16;
    localparam int SECTOR_W  = 9;
    localparam int SECTOR_LO = 15;
    localparam int PWD_WORDS = 4;
    localparam int PWD_AW    = 2;
    localparam int CNT_W     = 3;
    localparam int TIMER_W   = 8;
    localparam logic [SECTOR_W-1:0] BOOT_FIRST = 9'h101;

    // ------------------------------------------------------------
    // command codes and sequence lengths
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_PROGRAM     = 8'hA0;
    localparam logic [7:0] CMD_ERASE       = 8'h80;
    localparam logic [7:0] CMD_SECTOR_ERS  = 8'h30;
    localparam logic [7:0] CMD_PWD_UNLOCK  = 8'h25;
    localparam logic [7:0] CMD_PWD_PROG    = 8'h28;
    localparam logic [7:0] CMD_PWD_VERIFY  = 8'h29;
    localparam logic [7:0] CMD_PSL_PROG    = 8'h68;
    localparam logic [7:0] CMD_PSL_ERASE   = 8'h60;
    localparam logic [7:0] CMD_FREEZE_SET  = 8'h58;
    localparam logic [7:0] CMD_PERS_MODE   = 8'h4A;
    localparam logic [7:0] CMD_PWD_MODE    = 8'h4B;
    localparam logic [CNT_W-1:0] LEN_PROGRAM = 3'h4;
    localparam logic [CNT_W-1:0] LEN_ERASE   = 3'h6;
    localparam logic [CNT_W-1:0] LEN_UNLOCK  = 3'h5;
    localparam logic [CNT_W-1:0] LEN_TWO     = 3'h2;
    localparam logic [CNT_W-1:0] LEN_ONE     = 3'h1;
    localparam logic [CNT_W-1:0] LEN_NONE    = 3'h0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic FREEZE_RST = 1'b1;

    typedef enum logic [2:0] {
        ST_INIT, ST_IDLE, ST_SEQ, ST_MULTI, ST_CHECK, ST_POLL
    } fspl_phase_t;
endpackage

/* hdl/fspl_pwd_store.sv */
// password store: four words, registered read data
`timescale 1ns/1ps
module fspl_pwd_store (
    // clock
    input  wire logic                        ref_clk,
    input  wire logic                        ce,
    // write port
    input  wire logic                        wrEn,
    input  wire logic [fspl_pkg::PWD_AW-1:0] wrAddr,
    input  wire logic [fspl_pkg::DATA_W-1:0] wrData,
    // read port
    input  wire logic [fspl_pkg::PWD_AW-1:0] rdAddr,
    output logic      [fspl_pkg::DATA_W-1:0] rdData
);
    import fspl_pkg::*;

    logic [DATA_W-1:0] mem [PWD_WORDS];

    always_ff @(posedge ref_clk) begin
        if (ce) begin
            if (wrEn) begin
                mem[wrAddr] <= wrData;
            end
            rdData <= mem[rdAddr];
        end
    end
endmodule

/* hdl/fspl_lock_ctrl.sv */
// protection lock controller: mode bits, password unlock, pin locks
`timescale 1ns/1ps
// How it works
// - persistent-mode bit programmed blocks programming of password-mode bit.
// - password mode: freeze bit locked at power-up and reset release.
// - password mode: only correct 64-bit password unlocks freeze bit.
// - unlock compares passwords; match clears freeze, mismatch changes nothing.
// - every password check takes a fixed one microsecond delay.
// - before password-mode bit set, password program and verify allowed.
// - after password-mode bit set, password program and read ignored.
// - password-mode bit never erased; mode selection is permanent.
// - password-mode bit set blocks programming of persistent-mode bit.
// - password mode: reset, power-up or set command lock freeze bit.
// - unlock command ignored while in persistent protection mode.
// - write-guard low blocks program and erase of sectors 0x101 to 0x1FF.
// - write-guard high leaves boot sectors to software protection state.
// - fast-program pin low locks every sector.
// - write-guard sampled on fourth program write, sixth erase write.
// - extra erase sectors use write-guard latched on sixth write.
// - variant without boot sectors has no write-guard locking.
// - low supply rejects writes, aborts sequences, returns to read.
// - write cycle needs chip select and write strobe low, enable high.
// - writes during power-up not accepted; state machine goes to read.
// - freeze locked refuses program and erase of persistent sector locks.
// - command to protected sector ignored; brief polling then read mode (extra erase sectors: no polling, stays in ST_MULTI).
module fspl_lock_ctrl #(
    parameter bit HAS_BOOT = 1'b1
) (
    // clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    input  wire logic                          ce,
    // host strobes and buses
    input  wire logic                          chipSelN,
    input  wire logic                          writeEnN,
    input  wire logic                          outEnN,
    input  wire logic [fspl_pkg::ADDR_W-1:0]   hostAddr,
    input  wire logic [fspl_pkg::DATA_W-1:0]   hostData,
    // protection pins and supply monitor
    input  wire logic                          writeGuardN,
    input  wire logic                          fastProgramN,
    input  wire logic                          supplyLow,
    input  wire logic                          powerUp,
    // non-volatile mode bits, zero when programmed
    input  wire logic                          persistModeLockN,
    input  wire logic                          passwordModeLockN,
    // software lock of the addressed sector
    input  wire logic                          sectorSwLocked,
    // array operation requests
    output logic                               opGo,
    output logic                               opIsErase,
    output logic [fspl_pkg::SECTOR_W-1:0]      opSector,
    output logic                               opRejected,
    output logic                               pslGo,
    output logic                               pslIsErase,
    output logic [1:0]                         modeProgReq,
    // status
    output logic                               freezeLocked,
    output logic                               busy,
    output logic                               pwdRdValid,
    output logic [fspl_pkg::DATA_W-1:0]        pwdRdData
);
    import fspl_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        fspl_phase_t           phase;
        logic [7:0]            cmd;
        logic [CNT_W-1:0]      cnt;
        logic [TIMER_W-1:0]    timer;
        logic                  wpLatched;
        logic [PWD_WORDS*DATA_W-1:0] cand;
        logic                  mismatch;
        logic                  rdPend;
        logic                  weSeen;
        logic                  opGo;
        logic                  opIsErase;
        logic [SECTOR_W-1:0]   opSector;
        logic                  opRejected;
        logic                  pslGo;
        logic                  pslIsErase;
        logic [1:0]            modeProgReq;
        logic                  freezeLocked;
        logic                  busy;
        logic                  pwdRdValid;
        logic [DATA_W-1:0]     pwdRdData;
    } fspl_state_t;

    fspl_state_t st_r;
    fspl_state_t st_nxt;

    logic              memWrEn;
    logic [PWD_AW-1:0] memRdAddr;
    logic [DATA_W-1:0] memRdData;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [CNT_W-1:0] seqLen(input logic [7:0] c);
        case (c)
            CMD_PROGRAM:    seqLen = LEN_PROGRAM;
            CMD_ERASE:      seqLen = LEN_ERASE;
            CMD_PWD_UNLOCK: seqLen = LEN_UNLOCK;
            CMD_PWD_PROG,
            CMD_PWD_VERIFY,
            CMD_PSL_PROG:   seqLen = LEN_TWO;
            CMD_PSL_ERASE,
            CMD_FREEZE_SET,
            CMD_PERS_MODE,
            CMD_PWD_MODE:   seqLen = LEN_ONE;
            default:        seqLen = LEN_NONE;
        endcase
    endfunction

    function automatic logic isBoot(input logic [SECTOR_W-1:0] s);
        isBoot = HAS_BOOT && (s >= BOOT_FIRST);
    endfunction

    // software lock, boot guard (unless no boot variant), fast pin
    function automatic logic sectorLocked(input logic [SECTOR_W-1:0] s,
                                          input logic sw,
                                          input logic wp);
        sectorLocked = !fastProgramN || sw || (isBoot(s) && !wp);
    endfunction

    logic [SECTOR_W-1:0] addrSector;
    logic                writeActive;
    logic                writeTaken;
    logic                passMode;

    assign addrSector = hostAddr[SECTOR_LO +: SECTOR_W];
    assign writeActive = !chipSelN && !writeEnN && outEnN;
    // command taken on the rising edge of the write strobe
    assign writeTaken  = st_r.weSeen && writeEnN;
    assign passMode    = !passwordModeLockN;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [CNT_W-1:0] n;
        logic             wpNow;
        logic             locked;
        n      = '0;
        wpNow  = 1'b0;
        locked = 1'b0;
        st_nxt = st_r;
        st_nxt.opGo        = 1'b0;
        st_nxt.opRejected  = 1'b0;
        st_nxt.pslGo       = 1'b0;
        st_nxt.modeProgReq = 2'b00;
        st_nxt.pwdRdValid  = 1'b0;
        st_nxt.rdPend      = 1'b0;
        st_nxt.weSeen      = writeActive;
        memWrEn   = 1'b0;
        memRdAddr = hostAddr[PWD_AW-1:0];
        if (st_r.rdPend) begin
            st_nxt.pwdRdValid = 1'b1;
            st_nxt.pwdRdData  = memRdData;
        end
        case (st_r.phase)
            ST_INIT: begin
                // freeze follows mode once the mode bit is readable
                st_nxt.freezeLocked = passMode;
                st_nxt.phase        = ST_IDLE;
            end
            ST_IDLE, ST_SEQ: begin
                if (writeTaken) begin
                    n = (st_r.phase == ST_IDLE) ? LEN_ONE : st_r.cnt + 3'h1;
                    if (st_r.phase == ST_IDLE) begin
                        st_nxt.cmd = hostData[7:0];
                    end
                    st_nxt.cnt   = n;
                    st_nxt.phase = ST_SEQ;
                    // password words gathered after the command word
                    if (st_r.phase == ST_SEQ) begin
                        st_nxt.cand = {st_r.cand[PWD_WORDS*DATA_W-DATA_W-1:0],
                                       hostData};
                    end
                    if (n == seqLen(st_nxt.cmd) || seqLen(st_nxt.cmd) ==
                        LEN_NONE) begin
                        st_nxt.phase = ST_IDLE;
                        // write-guard sampled on the final write
                        wpNow  = writeGuardN;
                        locked = sectorLocked(addrSector, sectorSwLocked,
                                              wpNow);
                        case (st_nxt.cmd)
                            CMD_PROGRAM, CMD_ERASE: begin
                                st_nxt.wpLatched = wpNow;
                                st_nxt.opSector  = addrSector;
                                st_nxt.opIsErase = (st_nxt.cmd == CMD_ERASE);
                                if (locked) begin
                                    st_nxt.opRejected = 1'b1;
                                    st_nxt.busy       = 1'b1;
                                    st_nxt.timer      = '0;
                                    st_nxt.phase      = ST_POLL;
                                end else begin
                                    st_nxt.opGo  = 1'b1;
                                    st_nxt.phase = (st_nxt.cmd == CMD_ERASE) ?
                                                   ST_MULTI : ST_IDLE;
                                end
                            end
                            CMD_PWD_UNLOCK: begin
                                if (passMode) begin
                                    st_nxt.phase    = ST_CHECK;
                                    st_nxt.timer    = '0;
                                    st_nxt.mismatch = 1'b0;
                                    st_nxt.busy     = 1'b1;
                                end
                            end
                            CMD_PWD_PROG: begin
                                memWrEn = !passMode;
                            end
                            CMD_PWD_VERIFY: begin
                                st_nxt.rdPend = !passMode;
                            end
                            CMD_PSL_PROG, CMD_PSL_ERASE: begin
                                st_nxt.pslGo      = !st_r.freezeLocked;
                                st_nxt.pslIsErase = (st_nxt.cmd ==
                                                     CMD_PSL_ERASE);
                                st_nxt.opRejected = st_r.freezeLocked;
                            end
                            CMD_FREEZE_SET: begin
                                st_nxt.freezeLocked = 1'b1;
                            end
                            CMD_PERS_MODE: begin
                                st_nxt.modeProgReq[0] = !passMode;
                            end
                            CMD_PWD_MODE: begin
                                st_nxt.modeProgReq[1] = persistModeLockN;
                            end
                            default: begin
                                st_nxt.phase = ST_IDLE;
                            end
                        endcase
                    end
                end
            end
            ST_MULTI: begin
                if (writeTaken) begin
                    if (hostData[7:0] == CMD_SECTOR_ERS) begin
                        // guard latched on the sixth write reused
                        if (sectorLocked(addrSector, sectorSwLocked,
                                         st_r.wpLatched)) begin
                            st_nxt.opRejected = 1'b1;
                        end else begin
                            st_nxt.opGo = 1'b1;
                        end
                        st_nxt.opSector = addrSector;
                    end else begin
                        st_nxt.phase = ST_IDLE;
                    end
                end
            end
            ST_CHECK: begin
                // writes ignored while the comparison runs
                memRdAddr = st_r.timer[PWD_AW-1:0];
                st_nxt.timer = st_r.timer + 8'h01;
                if (st_r.timer >= 8'h01 && st_r.timer <= 8'h04) begin
                    // word by word compare, first word oldest
                    if (memRdData != st_r.cand[(8'h04 - st_r.timer) *
                                               DATA_W +: DATA_W]) begin
                        st_nxt.mismatch = 1'b1;
                    end
                end
                // outcome applied only at the end of the delay
                if (st_r.timer == TIMER_W'(CHECK_CYCLES - 1)) begin
                    if (!st_r.mismatch) begin
                        st_nxt.freezeLocked = 1'b0;
                    end
                    st_nxt.busy  = 1'b0;
                    st_nxt.phase = ST_IDLE;
                end
            end
            ST_POLL: begin
                st_nxt.timer = st_r.timer + 8'h01;
                if (st_r.timer == TIMER_W'(POLL_CYCLES - 1)) begin
                    st_nxt.busy  = 1'b0;
                    st_nxt.phase = ST_IDLE;
                end
            end
            default: begin
                st_nxt.phase = ST_IDLE;
            end
        endcase
        // low supply or power-up aborts everything except a password read already pending
        if (supplyLow || powerUp) begin
            st_nxt.phase      = powerUp ? ST_INIT : ST_IDLE;
            st_nxt.weSeen     = 1'b0;
            st_nxt.busy       = 1'b0;
            st_nxt.opGo       = 1'b0;
            st_nxt.pslGo      = 1'b0;
            st_nxt.opRejected = 1'b0;
            st_nxt.modeProgReq = 2'b00;
            st_nxt.rdPend     = 1'b0;
            memWrEn           = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
            // reset locks; persistent mode unlocks in ST_INIT
            st_r.freezeLocked <= FREEZE_RST;
            st_r.phase        <= ST_INIT;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    fspl_pwd_store u_store (
        .ref_clk (ref_clk),
        .ce      (ce),
        .wrEn    (memWrEn),
        .wrAddr  (hostAddr[PWD_AW-1:0]),
        .wrData  (hostData),
        .rdAddr  (memRdAddr),
        .rdData  (memRdData)
    );

    assign opGo         = st_r.opGo;
    assign opIsErase    = st_r.opIsErase;
    assign opSector     = st_r.opSector;
    assign opRejected   = st_r.opRejected;
    assign pslGo        = st_r.pslGo;
    assign pslIsErase   = st_r.pslIsErase;
    assign modeProgReq  = st_r.modeProgReq;
    assign freezeLocked = st_r.freezeLocked;
    assign busy         = st_r.busy;
    assign pwdRdValid   = st_r.pwdRdValid;
    assign pwdRdData    = st_r.pwdRdData;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst || !ce);

    property p_pwd_mode_blocked;
        modeProgReq[1] |-> $past(persistModeLockN);
    endproperty
    a_pwd_mode_blocked: assert property (p_pwd_mode_blocked)
        else $error("password mode bit programmed over persistent mode");

    property p_pers_mode_blocked;
        modeProgReq[0] |-> $past(passwordModeLockN);
    endproperty
    a_pers_mode_blocked: assert property (p_pers_mode_blocked)
        else $error("persistent mode bit programmed in password mode");

    property p_unlock_timed;
        $fell(freezeLocked) |->
            ($past(st_r.phase) == ST_INIT && $past(passwordModeLockN)) ||
            ($past(st_r.phase) == ST_CHECK &&
             $past(st_r.timer) == TIMER_W'(CHECK_CYCLES - 1));
    endproperty
    a_unlock_timed: assert property (p_unlock_timed)
        else $error("freeze cleared outside the timed check");

    property p_check_busy;
        (st_r.phase == ST_CHECK) |-> busy ##1
            (busy || !$past(st_r.timer == TIMER_W'(CHECK_CYCLES - 1)) ||
             st_r.phase == ST_IDLE);
    endproperty
    a_check_busy: assert property (p_check_busy)
        else $error("not busy during password check");

    property p_unlock_needs_mode;
        $rose(st_r.phase == ST_CHECK) |-> $past(passMode);
    endproperty
    a_unlock_needs_mode: assert property (p_unlock_needs_mode)
        else $error("password check started in persistent mode");

    property p_fast_pin;
        opGo |-> $past(fastProgramN);
    endproperty
    a_fast_pin: assert property (p_fast_pin)
        else $error("operation granted with fast-program pin low");

    property p_boot_guard;
        opGo && isBoot(opSector) |-> st_r.wpLatched;
    endproperty
    a_boot_guard: assert property (p_boot_guard)
        else $error("boot sector granted with guard low");

    property p_psl_freeze;
        pslGo |-> !$past(freezeLocked);
    endproperty
    a_psl_freeze: assert property (p_psl_freeze)
        else $error("persistent lock altered while frozen");

    property p_read_hidden;
        pwdRdValid |-> $past(passwordModeLockN, 2);
    endproperty
    a_read_hidden: assert property (p_read_hidden)
        else $error("password read in password mode");

    property p_supply_abort;
        supplyLow && !powerUp |=> st_r.phase == ST_IDLE && !busy;
    endproperty
    a_supply_abort: assert property (p_supply_abort)
        else $error("sequence not aborted on low supply");

    c_unlock: cover property ($fell(freezeLocked));
    c_reject: cover property (opRejected ##[1:8] !busy);
    c_multi:  cover property (opGo && opIsErase ##[1:20] opGo);
endmodule

/* testbench/fspl_host.sv */
// host controller model driving command writes
`timescale 1ns/1ps
module fspl_host (
    // host bus
    input  wire logic        ref_clk,
    output logic             chipSelN,
    output logic             writeEnN,
    output logic             outEnN,
    output logic [23:0]      hostAddr,
    output logic [15:0]      hostData
);
    initial {chipSelN, writeEnN, outEnN, hostAddr, hostData} = '1;
    // select and strobe low, output enable high
    task automatic put(input logic [23:0] a, input logic [15:0] d);
        @(negedge ref_clk);
        {chipSelN, writeEnN, hostAddr, hostData} = {2'b00, a, d};
        @(negedge ref_clk);
        writeEnN = 1'b1;
        // released bus must not show stale data
        @(negedge ref_clk);
        {chipSelN, hostData} = {1'b1, ~d};
    endtask
endmodule

/* testbench/tb.sv */
// self-checking bench of the protection lock controller
`timescale 1ns/1ps
module tb;
    import fspl_pkg::*;
    localparam logic [23:0] BOOT = 24'h808000;
    localparam logic [23:0] LOW  = 24'h010000;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        writeGuardN = 1'b1;
    logic        fastProgramN = 1'b1;
    logic        passwordModeLockN = 1'b1;
    logic        supplyLow = 1'b0;
    logic        persistModeLockN = 1'b1;
    logic        chipSelN, writeEnN, outEnN, opGo, opRejected;
    logic        busy, freezeLocked, pwdRdValid, sGo, sRej, sRd, sBusy, sPsl;
    logic        pslGo;
    logic [1:0]  modeReq, sMode;
    logic [23:0] hostAddr;
    logic [15:0] hostData, pwdRdData, rdVal;
    logic [15:0] pw [4] = '{16'h1234, 16'hABCD, 16'h0F0F, 16'hC3A5};
    int          mismatches = 0;
    int          nTests = 0;
    int          n;
    always #2.5 ref_clk = ~ref_clk;
    fspl_host host (.ref_clk(ref_clk), .chipSelN(chipSelN),
        .writeEnN(writeEnN), .outEnN(outEnN), .hostAddr(hostAddr),
        .hostData(hostData));
    fspl_lock_ctrl dut (.ref_clk(ref_clk), .rst(rst), .ce(1'b1),
        .chipSelN(chipSelN), .writeEnN(writeEnN), .outEnN(outEnN),
        .hostAddr(hostAddr), .hostData(hostData), .supplyLow(supplyLow),
        .writeGuardN(writeGuardN), .fastProgramN(fastProgramN),
        .powerUp(1'b0), .persistModeLockN(persistModeLockN),
        .sectorSwLocked(1'b0),
        .passwordModeLockN(passwordModeLockN), .opGo(opGo),
        .opIsErase(), .opSector(), .opRejected(opRejected), .pslGo(pslGo),
        .pslIsErase(), .modeProgReq(modeReq), .freezeLocked(freezeLocked),
        .busy(busy), .pwdRdValid(pwdRdValid), .pwdRdData(pwdRdData));
    task automatic chk(input logic [15:0] s, e, input string m);
        nTests++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic watch(input int c);
        {sGo, sRej, sRd, sBusy, sPsl, sMode} = '0;
        // pulses from the last take edge still stand on entry
        repeat (c + 1) begin
            sGo |= opGo;
            sRej |= opRejected;
            sRd |= pwdRdValid;
            sBusy |= busy;
            sPsl |= pslGo;
            sMode |= modeReq;
            if (pwdRdValid === 1'b1) rdVal = pwdRdData;
            @(negedge ref_clk);
        end
    endtask
    task automatic t_modes;
        host.put(24'h0, {8'h00, CMD_PSL_PROG});
        host.put(24'h0, 16'h0);
        watch(2);
        chk({sPsl, sRej}, 2'b10, "lock bit program");
        host.put(24'h0, {8'h00, CMD_FREEZE_SET});
        host.put(24'h0, {8'h00, CMD_PSL_ERASE});
        watch(2);
        chk({sPsl, sRej}, 2'b01, "frozen lock erase");
        host.put(24'h0, {8'h00, CMD_PWD_MODE});
        watch(2);
        chk({14'h0, sMode}, 16'h2, "password mode request");
        persistModeLockN = 1'b0;
        host.put(24'h0, {8'h00, CMD_PWD_MODE});
        watch(2);
        chk({14'h0, sMode}, 16'h0, "password mode refused");
        host.put(24'h0, {8'h00, CMD_PERS_MODE});
        watch(2);
        chk({14'h0, sMode}, 16'h1, "persistent mode request");
        persistModeLockN = 1'b1;
        host.put(24'h0, {8'h00, CMD_PROGRAM});
        supplyLow = 1'b1;
        @(negedge ref_clk);
        supplyLow = 1'b0;
        repeat (3) host.put(LOW, 16'h0);
        watch(2);
        chk({15'h0, sGo}, 16'h0, "low supply abort");
    endtask
    task automatic prog(input logic [23:0] a);
        host.put(24'h0, {8'h00, CMD_PROGRAM});
        repeat (2) host.put(24'h0, 16'h0);
        host.put(a, 16'h0);
        watch(8);
    endtask
    task automatic unlock(input logic [15:0] w [4]);
        host.put(24'h0, {8'h00, CMD_PWD_UNLOCK});
        foreach (w[i]) host.put(24'h0, w[i]);
        if (busy !== 1'b1) @(negedge ref_clk);
        sBusy = busy;
        // count the check delay, bounded against a hang
        for (n = 0; busy === 1'b1 && n < 400; n++) @(negedge ref_clk);
    endtask
    task automatic t_pers;
        for (int i = 0; i < 4; i++) begin
            host.put(24'h0, {8'h00, CMD_PWD_PROG});
            host.put(24'(i), pw[i]);
        end
        host.put(24'h0, {8'h00, CMD_PWD_VERIFY});
        host.put(24'h2, 16'h0);
        watch(4);
        chk({15'h0, sRd}, 16'h1, "verify pulse");
        chk(rdVal, pw[2], "verify data");
        unlock(pw);
        chk({sBusy, freezeLocked}, 2'b00, "unlock ignored");
    endtask
    task automatic t_guard;
        writeGuardN = 1'b0;
        prog(BOOT);
        chk({sRej, sGo}, 2'b10, "guard low boot");
        prog(LOW);
        chk({sRej, sGo}, 2'b01, "guard low plain");
        writeGuardN = 1'b1;
        prog(BOOT);
        chk({sRej, sGo}, 2'b01, "guard high boot");
        fastProgramN = 1'b0;
        prog(LOW);
        chk({sRej, sGo, sBusy}, 3'b101, "fast pin");
        fastProgramN = 1'b1;
    endtask
    task automatic t_multi;
        host.put(24'h0, {8'h00, CMD_ERASE});
        repeat (4) host.put(24'h0, 16'h0);
        host.put(BOOT, {8'h00, CMD_SECTOR_ERS});
        watch(2);
        chk({15'h0, sGo}, 16'h1, "erase grant");
        writeGuardN = 1'b0;
        host.put(BOOT, {8'h00, CMD_SECTOR_ERS});
        watch(2);
        chk({15'h0, sGo}, 16'h1, "latched guard");
        writeGuardN = 1'b1;
        host.put(24'h0, 16'h0);
    endtask
    task automatic t_pwd;
        logic [15:0] bad [4];
        bad = pw;
        bad[3] = 16'h0000;
        passwordModeLockN = 1'b0;
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        chk({15'h0, freezeLocked}, 16'h1, "locked at reset");
        host.put(24'h0, {8'h00, CMD_PWD_VERIFY});
        host.put(24'h1, 16'h0);
        watch(4);
        chk({15'h0, sRd}, 16'h0, "verify hidden");
        unlock(bad);
        chk({sBusy, freezeLocked}, 2'b11, "wrong password");
        unlock(pw);
        chk(n[15:0], 16'(CHECK_CYCLES), "check delay");
        chk({15'h0, freezeLocked}, 16'h0, "unlocked");
        host.put(24'h0, {8'h00, CMD_FREEZE_SET});
        watch(2);
        chk({15'h0, freezeLocked}, 16'h1, "freeze set");
        host.put(24'h0, {8'h00, CMD_PERS_MODE});
        watch(2);
        chk({14'h0, sMode}, 16'h0, "persistent mode refused");
    endtask
    task automatic close_out;
        if (mismatches == 0 && nTests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        repeat (2) @(negedge ref_clk);
        t_pers;
        t_modes;
        t_guard;
        t_multi;
        t_pwd;
        close_out;
    end
    // whole run is under a thousand cycles
    initial begin
        #100000;
        mismatches++;
        close_out;
    end
endmodule
